/* File: scd_pkg.sv */
// Operation
// - version query answers 0x82: bit7 set, bit6 clear, version in 5:0.
// - status query answers 0xc0 or 0xc1, bit0 meaning alive.
// - bootloader frame command is followed by a length byte.
// - network api frame command is followed by a length byte.
// - unsupported or reserved command byte is dropped, answered 0x04.
// - error codes 0x00-0x04 only, each followed by a detail byte.
// - while an error is pending any command gets the pending error.
// - length above 133 drops the command and reports 0x01.
// - transaction ended early is aborted and reports 0x02.
// - missing terminator drops the command and reports 0x03.
// - after reset assert attention, answer next command 0x00 and cause.
// - attention released after a received byte, then normal decoding.
// - bootloader mode if wake or trace pin low at reset release.
// - slave select going idle reinitialises the protocol state.
// - slave select active at power on: ignore data until idle.
// - every command and response ends with terminator 0xa7.
// - payload length counts payload only, range 2 to 133; lengths 0 and 1 are accepted too.
// - send 0xff outside response, ignore bytes outside command.
// - back to back errors: only the first is reported.
package scd_pkg;

	// ---------------------------------------------------------------
	// byte codes
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_VERSION   = 8'h0a;
	localparam logic [7:0] CMD_STATUS    = 8'h0b;
	localparam logic [7:0] CMD_BOOT      = 8'hfd;
	localparam logic [7:0] CMD_NET       = 8'hfe;
	localparam logic [7:0] RSP_VERSION   = 8'h82;
	localparam logic [7:0] RSP_STATUS    = 8'hc0;
	localparam logic [7:0] ERR_RESET     = 8'h00;
	localparam logic [7:0] ERR_OVERSIZE  = 8'h01;
	localparam logic [7:0] ERR_ABORT     = 8'h02;
	localparam logic [7:0] ERR_NO_TERM   = 8'h03;
	localparam logic [7:0] ERR_UNSUP     = 8'h04;
	localparam logic [7:0] ERR_DETAIL    = 8'h00;
	localparam logic [7:0] FRAME_TERM    = 8'ha7;
	localparam logic [7:0] IDLE_BYTE     = 8'hff;
	localparam logic [7:0] MAX_PAY_LEN   = 8'h85;
	localparam int         STATUS_ALIVE_BIT = 0;

	// ---------------------------------------------------------------
	// response kinds, synchroniser layout, strap timing
	// ---------------------------------------------------------------
	localparam logic [1:0] KIND_ERR  = 2'h0;
	localparam logic [1:0] KIND_VER  = 2'h1;
	localparam logic [1:0] KIND_STAT = 2'h2;
	localparam logic [1:0] KIND_APP  = 2'h3;
	localparam int         SYNC_W    = 3;
	localparam int         SY_SSEL   = 0;
	localparam int         SY_WAKE   = 1;
	localparam int         SY_TRACE  = 2;
	localparam logic [SYNC_W-1:0] SYNC_RST = 3'h7;
	localparam logic [1:0] STRAP_CYC = 2'h3;

	typedef enum logic [7:0] {
		ST_WAIT_IDLE = 8'h01,
		ST_CMD       = 8'h02,
		ST_LEN       = 8'h04,
		ST_PAY       = 8'h08,
		ST_TERM      = 8'h10,
		ST_SKIP      = 8'h20,
		ST_RESP      = 8'h40,
		ST_DONE      = 8'h80
	} scd_state_type;

	typedef struct packed {
		logic       vld;
		logic [7:0] dat;
	} scd_byte_type;

	typedef struct packed {
		logic       vld;
		logic       first;
		logic       boot;
		logic [7:0] dat;
	} scd_pay_type;

	typedef struct packed {
		logic       vld;
		logic       last;
		logic [7:0] dat;
	} scd_app_type;

endpackage

/* File: scd_sync.sv */
`timescale 1ns/10ps
module scd_sync (
	input  wire logic                         i_clk,     // system clock
	input  wire logic                         i_sys_rst, // sync reset
	input  wire logic [scd_pkg::SYNC_W-1:0]   i_async,   // raw pins
	output logic      [scd_pkg::SYNC_W-1:0]   o_sync     // synchronised
);

	logic [scd_pkg::SYNC_W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			meta_r <= scd_pkg::SYNC_RST;
			o_sync <= scd_pkg::SYNC_RST;
		end
		else
		begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule

/* File: scd_frame_decoder.sv */
`timescale 1ns/10ps
module scd_frame_decoder (
	input  wire logic                 i_clk,             // 100 MHz clock
	input  wire logic                 i_sys_rst,         // sync reset
	input  wire logic                 i_ssel_n,          // slave select pin
	input  wire logic                 i_wake_request_n,  // strap pin
	input  wire logic                 i_trace_data_pin,  // strap pin
	input  wire scd_pkg::scd_byte_type i_rx,             // byte from shifter
	input  wire logic                 i_tx_req,          // shifter wants byte
	input  wire logic [7:0]           i_reset_cause_code, // reset cause
	input  wire logic                 i_alive,           // stack ready
	input  wire scd_pkg::scd_app_type i_app_rsp,         // frame response
	output logic                      o_app_rsp_ready,   // app byte taken
	output logic [7:0]                o_tx_byte,         // byte to shifter
	output scd_pkg::scd_pay_type      o_pay,             // payload stream
	output logic                      o_pay_commit,      // frame good
	output logic                      o_pay_drop,        // frame dropped
	output logic                      o_host_attention_n, // attention
	output logic                      o_boot_mode        // bootloader mode
);

	// ---------------------------------------------------------------
	// pin synchronisation and strap capture
	// ---------------------------------------------------------------
	logic [scd_pkg::SYNC_W-1:0] pins_s;
	logic                       ss_idle_d_r;
	logic [1:0]                 strap_cnt_r;
	logic                       strap_done_r;

	scd_sync u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   ({i_trace_data_pin, i_wake_request_n, i_ssel_n}),
		.o_sync    (pins_s)
	);

	logic ss_idle;
	logic ss_rise;
	assign ss_idle = pins_s[scd_pkg::SY_SSEL];
	assign ss_rise = ss_idle & ~ss_idle_d_r;

	// pins are sampled once the synchroniser holds post-release values
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			strap_cnt_r  <= 2'h0;
			strap_done_r <= 1'b0;
			o_boot_mode  <= 1'b0;
		end
		else if (!strap_done_r)
		begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == scd_pkg::STRAP_CYC - 2'h1)
			begin
				strap_done_r <= 1'b1;
				o_boot_mode  <= ~pins_s[scd_pkg::SY_WAKE] |
				                ~pins_s[scd_pkg::SY_TRACE];
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			ss_idle_d_r <= 1'b1;
		else
			ss_idle_d_r <= ss_idle;
	end

	// ---------------------------------------------------------------
	// error bookkeeping
	// ---------------------------------------------------------------
	scd_pkg::scd_state_type state_r;
	logic                   err_pend_r;
	logic [7:0]             err_code_r;
	logic                   err_req;
	logic [7:0]             err_req_code;
	logic                   err_clr;
	logic                   note_unseen_r;
	logic [1:0]             kind_r;
	logic [1:0]             idx_r;
	logic                   term_ph_r;
	logic [7:0]             cnt_r;
	logic                   boot_frame_r;
	logic                   rx_ok;

	// bytes only count while slave select is active, in any state
	assign rx_ok = i_rx.vld & ~ss_idle;

	function automatic logic in_cmd(input scd_pkg::scd_state_type s);
		in_cmd = (s == scd_pkg::ST_LEN) || (s == scd_pkg::ST_PAY) ||
		         (s == scd_pkg::ST_TERM) || (s == scd_pkg::ST_SKIP);
	endfunction

	always_comb
	begin
		err_req      = 1'b0;
		err_req_code = scd_pkg::ERR_ABORT;
		if (ss_rise && (in_cmd(state_r) || state_r == scd_pkg::ST_RESP))
			err_req = 1'b1;
		else if (rx_ok && state_r == scd_pkg::ST_CMD && !err_pend_r &&
		         !((i_rx.dat == scd_pkg::CMD_VERSION) ||
		           (i_rx.dat == scd_pkg::CMD_STATUS) ||
		           (i_rx.dat == scd_pkg::CMD_BOOT && o_boot_mode) ||
		           (i_rx.dat == scd_pkg::CMD_NET && !o_boot_mode)))
		begin
			err_req      = 1'b1;
			err_req_code = scd_pkg::ERR_UNSUP;
		end
		else if (rx_ok && state_r == scd_pkg::ST_LEN &&
		         i_rx.dat > scd_pkg::MAX_PAY_LEN)
		begin
			err_req      = 1'b1;
			err_req_code = scd_pkg::ERR_OVERSIZE;
		end
		else if (rx_ok && state_r == scd_pkg::ST_TERM &&
		         i_rx.dat != scd_pkg::FRAME_TERM)
		begin
			err_req      = 1'b1;
			err_req_code = scd_pkg::ERR_NO_TERM;
		end
	end

	assign err_clr = i_tx_req && state_r == scd_pkg::ST_RESP &&
	                 kind_r == scd_pkg::KIND_ERR &&
	                 idx_r == 2'h2 && !ss_idle;

	// a new error wins over the clear; later errors never overwrite
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			err_pend_r <= 1'b1;
			err_code_r <= scd_pkg::ERR_RESET;
		end
		else if (err_req && (!err_pend_r || err_clr))
		begin
			err_pend_r <= 1'b1;
			err_code_r <= err_req_code;
		end
		else if (err_clr)
			err_pend_r <= 1'b0;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			note_unseen_r <= 1'b1;
		else if (rx_ok && state_r != scd_pkg::ST_WAIT_IDLE)
			note_unseen_r <= 1'b0;
	end

	// ---------------------------------------------------------------
	// frame state machine
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			state_r      <= scd_pkg::ST_WAIT_IDLE;
			kind_r       <= scd_pkg::KIND_ERR;
			cnt_r        <= 8'h00;
			boot_frame_r <= 1'b0;
		end
		else if (ss_rise)
			state_r <= scd_pkg::ST_CMD;
		else
		begin
			case (state_r)
			// synchroniser resets to idle: trust it only once it holds pins
			scd_pkg::ST_WAIT_IDLE:
				if (ss_idle && strap_done_r)
					state_r <= scd_pkg::ST_CMD;
			scd_pkg::ST_CMD:
				if (rx_ok)
				begin
					boot_frame_r <= (i_rx.dat == scd_pkg::CMD_BOOT);
					kind_r       <= scd_pkg::KIND_ERR;
					if (err_pend_r || err_req)
						state_r <= scd_pkg::ST_SKIP;
					else if (i_rx.dat == scd_pkg::CMD_VERSION)
					begin
						kind_r  <= scd_pkg::KIND_VER;
						state_r <= scd_pkg::ST_TERM;
					end
					else if (i_rx.dat == scd_pkg::CMD_STATUS)
					begin
						kind_r  <= scd_pkg::KIND_STAT;
						state_r <= scd_pkg::ST_TERM;
					end
					else
					begin
						kind_r  <= scd_pkg::KIND_APP;
						state_r <= scd_pkg::ST_LEN;
					end
				end
			scd_pkg::ST_LEN:
				if (rx_ok)
				begin
					cnt_r <= i_rx.dat;
					if (err_req)
						state_r <= scd_pkg::ST_DONE;
					else if (i_rx.dat == 8'h00)
						state_r <= scd_pkg::ST_TERM;
					else
						state_r <= scd_pkg::ST_PAY;
				end
			scd_pkg::ST_PAY:
				if (rx_ok)
				begin
					cnt_r <= cnt_r - 8'h01;
					if (cnt_r == 8'h01)
						state_r <= scd_pkg::ST_TERM;
				end
			scd_pkg::ST_TERM:
				if (rx_ok)
				begin
					// a bad terminator is answered at once
					if (err_req)
						kind_r <= scd_pkg::KIND_ERR;
					state_r <= scd_pkg::ST_RESP;
				end
			scd_pkg::ST_SKIP:
				if (rx_ok && i_rx.dat == scd_pkg::FRAME_TERM)
					state_r <= scd_pkg::ST_RESP;
			scd_pkg::ST_RESP:
				if (i_tx_req && !ss_idle)
				begin
					if ((kind_r == scd_pkg::KIND_ERR && idx_r == 2'h2) ||
					    (kind_r == scd_pkg::KIND_APP && term_ph_r) ||
					    ((kind_r == scd_pkg::KIND_VER ||
					      kind_r == scd_pkg::KIND_STAT) && idx_r == 2'h1))
						state_r <= scd_pkg::ST_DONE;
				end
			scd_pkg::ST_DONE:
				state_r <= scd_pkg::ST_DONE;
			default:
				state_r <= scd_pkg::ST_WAIT_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// payload stream towards the stack or bootloader
	// ---------------------------------------------------------------
	logic pay_first_r;

	// set by the length byte, so it marks the byte right after it
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			pay_first_r <= 1'b0;
		else if (rx_ok)
			pay_first_r <= state_r == scd_pkg::ST_LEN;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_pay        <= '0;
			o_pay_commit <= 1'b0;
			o_pay_drop   <= 1'b0;
		end
		else
		begin
			o_pay.vld    <= rx_ok && state_r == scd_pkg::ST_PAY && !ss_rise;
			o_pay.dat    <= i_rx.dat;
			o_pay.boot   <= boot_frame_r;
			o_pay.first  <= state_r == scd_pkg::ST_PAY && pay_first_r;
			o_pay_commit <= rx_ok && !ss_rise &&
			                state_r == scd_pkg::ST_TERM &&
			                kind_r == scd_pkg::KIND_APP && !err_req;
			o_pay_drop   <= (ss_rise && (state_r == scd_pkg::ST_PAY ||
			                 (state_r == scd_pkg::ST_TERM &&
			                  kind_r == scd_pkg::KIND_APP))) ||
			                (!ss_rise && rx_ok && err_req &&
			                 state_r == scd_pkg::ST_TERM &&
			                 kind_r == scd_pkg::KIND_APP);
		end
	end

	// ---------------------------------------------------------------
	// response sequencer
	// ---------------------------------------------------------------
	logic tx_go;
	assign tx_go = i_tx_req && state_r == scd_pkg::ST_RESP && !ss_idle;
	assign o_app_rsp_ready = tx_go && kind_r == scd_pkg::KIND_APP &&
	                         !term_ph_r;

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_tx_byte <= scd_pkg::IDLE_BYTE;
			idx_r     <= 2'h0;
			term_ph_r <= 1'b0;
		end
		else if (!tx_go)
		begin
			if (state_r != scd_pkg::ST_RESP)
			begin
				idx_r     <= 2'h0;
				term_ph_r <= 1'b0;
			end
			if (i_tx_req)
				o_tx_byte <= scd_pkg::IDLE_BYTE;
		end
		else
		begin
			idx_r <= idx_r + 2'h1;
			case (kind_r)
			scd_pkg::KIND_ERR:
				case (idx_r)
				2'h0:    o_tx_byte <= err_code_r;
				2'h1:    o_tx_byte <= (err_code_r == scd_pkg::ERR_RESET) ?
				                      i_reset_cause_code :
				                      scd_pkg::ERR_DETAIL;
				default: o_tx_byte <= scd_pkg::FRAME_TERM;
				endcase
			scd_pkg::KIND_VER:
				o_tx_byte <= (idx_r == 2'h0) ? scd_pkg::RSP_VERSION :
				             scd_pkg::FRAME_TERM;
			scd_pkg::KIND_STAT:
				o_tx_byte <= (idx_r == 2'h0) ?
				             (scd_pkg::RSP_STATUS |
				              {7'h00, i_alive}) :
				             scd_pkg::FRAME_TERM;
			default:
				if (term_ph_r)
					o_tx_byte <= scd_pkg::FRAME_TERM;
				else if (i_app_rsp.vld)
				begin
					o_tx_byte <= i_app_rsp.dat;
					term_ph_r <= i_app_rsp.last;
				end
				else
					o_tx_byte <= scd_pkg::IDLE_BYTE;
			endcase
		end
	end

	// attention: fresh reset, response ready, or error awaiting a poll
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			o_host_attention_n <= 1'b1;
		else
			o_host_attention_n <= ~((note_unseen_r && !rx_ok) ||
			    (state_r == scd_pkg::ST_RESP &&
			     (kind_r != scd_pkg::KIND_APP || i_app_rsp.vld)) ||
			    (!note_unseen_r && err_pend_r && ss_idle &&
			     state_r == scd_pkg::ST_CMD));
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_version;
		@(posedge i_clk) disable iff (i_sys_rst)
		tx_go && kind_r == scd_pkg::KIND_VER && idx_r == 2'h0
		|=> o_tx_byte == 8'h82;
	endproperty
	a_version: assert property (p_version)
		else $error("version reply wrong");

	property p_status;
		@(posedge i_clk) disable iff (i_sys_rst)
		tx_go && kind_r == scd_pkg::KIND_STAT && idx_r == 2'h0
		|=> o_tx_byte[7:1] == 7'h60 && o_tx_byte[0] == $past(i_alive);
	endproperty
	a_status: assert property (p_status)
		else $error("status reply wrong");

	property p_err_code;
		@(posedge i_clk) disable iff (i_sys_rst)
		tx_go && kind_r == scd_pkg::KIND_ERR && idx_r == 2'h0
		|=> o_tx_byte <= 8'h04 ##1 1'b1 ##[0:300] o_tx_byte == 8'ha7;
	endproperty
	a_err_code: assert property (p_err_code)
		else $error("error reply malformed");

	property p_oversize;
		@(posedge i_clk) disable iff (i_sys_rst)
		rx_ok && !ss_rise && !err_pend_r && state_r == scd_pkg::ST_LEN &&
		i_rx.dat > 8'h85
		|=> err_pend_r && err_code_r == 8'h01 &&
		    state_r == scd_pkg::ST_DONE;
	endproperty
	a_oversize: assert property (p_oversize)
		else $error("oversize not flagged");

	property p_abort;
		@(posedge i_clk) disable iff (i_sys_rst)
		ss_rise && !err_pend_r && state_r == scd_pkg::ST_PAY
		|=> err_code_r == 8'h02 && state_r == scd_pkg::ST_CMD && o_pay_drop;
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort not flagged");

	property p_first_err;
		@(posedge i_clk) disable iff (i_sys_rst)
		err_pend_r && !err_clr |=> $stable(err_code_r) && err_pend_r;
	endproperty
	a_first_err: assert property (p_first_err)
		else $error("pending error overwritten");

	property p_idle_fill;
		@(posedge i_clk) disable iff (i_sys_rst)
		i_tx_req && state_r != scd_pkg::ST_RESP |=> o_tx_byte == 8'hff;
	endproperty
	a_idle_fill: assert property (p_idle_fill)
		else $error("non-idle byte outside response");

	property p_resync;
		@(posedge i_clk) disable iff (i_sys_rst)
		ss_rise |=> state_r == scd_pkg::ST_CMD && !o_pay.vld;
	endproperty
	a_resync: assert property (p_resync)
		else $error("no reinit on select idle");

	property p_clear;
		@(posedge i_clk) disable iff (i_sys_rst)
		err_clr && !err_req |=> !err_pend_r && o_tx_byte == 8'ha7;
	endproperty
	a_clear: assert property (p_clear)
		else $error("error not cleared after reply");

	property p_unsup;
		@(posedge i_clk) disable iff (i_sys_rst)
		rx_ok && !ss_rise && !err_pend_r && state_r == scd_pkg::ST_CMD &&
		i_rx.dat == 8'h05
		|=> err_code_r == 8'h04 && state_r == scd_pkg::ST_SKIP;
	endproperty
	a_unsup: assert property (p_unsup)
		else $error("reserved command accepted");

endmodule

/* File: scd_host_model.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// host side: spi master seen at byte level
// ---------------------------------------------------------------
module scd_host_model (
	input  wire logic             i_clk,     // system clock
	input  wire logic [7:0]       i_tx_byte, // byte from device
	output logic                  o_ssel_n,  // slave select
	output scd_pkg::scd_byte_type o_rx,      // byte to device
	output logic                  o_tx_req   // ask for next byte
);
	initial
	begin
		o_ssel_n = 1'b1;
		o_rx = '0;
		o_tx_req = 1'b0;
	end

	// long settle so the synchronised select has surely moved
	task automatic sel(input logic on);
		@(negedge i_clk);
		o_ssel_n = !on;
		repeat (5) @(negedge i_clk);
	endtask

	// request first, so the reply is read before our byte lands
	task automatic xfer(input logic [7:0] b, output logic [7:0] got);
		@(negedge i_clk);
		o_tx_req = 1'b1;
		@(negedge i_clk);
		o_tx_req = 1'b0;
		got = i_tx_byte;
		o_rx = {1'b1, b};
		@(negedge i_clk);
		// idle data line never repeats the last byte
		o_rx = {1'b0, ~b};
		repeat (3) @(negedge i_clk);
	endtask
endmodule

/* File: test_spi_frame_command_decoder.sv */
`timescale 1ns/10ps
module test_spi_frame_command_decoder;
	logic [7:0]            cause = 8'h02;
	logic                  i_clk;
	logic                  i_sys_rst;
	logic                  i_ssel_n;
	logic                  i_wake_request_n;
	logic                  i_trace_data_pin;
	logic                  i_tx_req;
	logic                  i_alive;
	logic                  o_app_rsp_ready;
	logic                  o_pay_commit;
	logic                  o_pay_drop;
	logic                  o_host_attention_n;
	logic                  o_boot_mode;
	logic [7:0]            o_tx_byte;
	logic [7:0]            pay_last;
	logic                  pay_boot;
	logic [7:0]            app_q[$];
	scd_pkg::scd_byte_type i_rx;
	scd_pkg::scd_app_type  i_app_rsp;
	scd_pkg::scd_pay_type  o_pay;
	int                    app_idx = 0;
	int                    pay_cnt = 0;
	int                    first_cnt = 0;
	int                    commit_cnt = 0;
	int                    drop_cnt = 0;
	int                    fails = 0;
	int                    checks_done = 0;

	scd_frame_decoder dut (
		.i_clk              (i_clk),
		.i_sys_rst          (i_sys_rst),
		.i_ssel_n           (i_ssel_n),
		.i_wake_request_n   (i_wake_request_n),
		.i_trace_data_pin   (i_trace_data_pin),
		.i_rx               (i_rx),
		.i_tx_req           (i_tx_req),
		.i_reset_cause_code (cause),
		.i_alive            (i_alive),
		.i_app_rsp          (i_app_rsp),
		.o_app_rsp_ready    (o_app_rsp_ready),
		.o_tx_byte          (o_tx_byte),
		.o_pay              (o_pay),
		.o_pay_commit       (o_pay_commit),
		.o_pay_drop         (o_pay_drop),
		.o_host_attention_n (o_host_attention_n),
		.o_boot_mode        (o_boot_mode)
	);

	scd_host_model host (
		.i_clk     (i_clk),
		.i_tx_byte (o_tx_byte),
		.o_ssel_n  (i_ssel_n),
		.o_rx      (i_rx),
		.o_tx_req  (i_tx_req)
	);

	// ---------------------------------------------------------------
	// clock, stack side response feed, payload monitor
	// ---------------------------------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	always @(posedge i_clk)
		if (i_app_rsp.vld && o_app_rsp_ready === 1'b1)
			app_idx <= app_idx + 1;

	always_comb
		i_app_rsp = (app_idx < app_q.size()) ?
			{1'b1, app_idx == app_q.size() - 1, app_q[app_idx]} : '0;

	always @(posedge i_clk)
	begin
		if (o_pay.vld === 1'b1)
		begin
			pay_cnt <= pay_cnt + 1;
			if (o_pay.first === 1'b1)
				first_cnt <= first_cnt + 1;
			pay_last <= o_pay.dat;
			pay_boot <= o_pay.boot;
		end
		if (o_pay_commit === 1'b1)
			commit_cnt <= commit_cnt + 1;
		if (o_pay_drop === 1'b1)
			drop_cnt <= drop_cnt + 1;
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmd(input logic [7:0] q[$]);
		logic [7:0] got;
		foreach (q[i])
		begin
			host.xfer(q[i], got);
			chk(got, scd_pkg::IDLE_BYTE);
		end
	endtask

	task automatic rsp(input logic [7:0] q[$]);
		logic [7:0] got;
		foreach (q[i])
		begin
			host.xfer(scd_pkg::IDLE_BYTE, got);
			chk(got, q[i]);
		end
	endtask

	task automatic txn(input logic [7:0] c[$], input logic [7:0] r[$]);
		host.sel(1'b1);
		cmd(c);
		rsp(r);
		host.sel(1'b0);
	endtask

	task automatic do_reset(input logic wake_n, input logic trace_n);
		i_wake_request_n = wake_n;
		i_trace_data_pin = trace_n;
		i_sys_rst = 1'b1;
		repeat (10) @(negedge i_clk);
		i_sys_rst = 1'b0;
		repeat (6) @(negedge i_clk);
		chk({7'h0, o_boot_mode}, {7'h0, !(wake_n && trace_n)});
		chk({7'h0, o_host_attention_n}, 8'h00);
		i_wake_request_n = 1'b1;
		i_trace_data_pin = 1'b1;
	endtask

	task automatic final_report;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_notice;
		cmd('{8'h0a, 8'ha7});
		rsp('{8'hff, 8'hff});
		host.sel(1'b0);
		host.sel(1'b1);
		cmd('{8'h0b});
		chk({7'h0, o_host_attention_n}, 8'h01);
		cmd('{8'ha7});
		rsp('{8'h00, cause, 8'ha7, 8'hff});
		host.sel(1'b0);
	endtask

	task automatic t_status;
		i_alive = 1'b0;
		txn('{8'h0b, 8'ha7}, '{8'hc0, 8'ha7, 8'hff});
		i_alive = 1'b1;
		txn('{8'h0b, 8'ha7}, '{8'hc1, 8'ha7, 8'hff});
	endtask

	task automatic t_frame(input int n);
		logic [7:0] q[$];
		int p = pay_cnt;
		int c = commit_cnt;
		int f = first_cnt;
		q = '{8'hfe, 8'(n)};
		for (int i = 0; i < n; i++)
			q.push_back(8'(i + 1));
		q.push_back(8'ha7);
		app_q = {};
		host.sel(1'b1);
		cmd(q);
		chk(8'(pay_cnt - p), 8'(n));
		chk(8'(commit_cnt - c), 8'h01);
		chk(pay_last, 8'(n));
		chk(8'(first_cnt - f), 8'h01);
		chk({7'h0, pay_boot}, 8'h00);
		rsp('{8'hff});
		app_idx = 0;
		app_q = '{8'hfe, 8'h01, 8'h55};
		rsp('{8'hfe, 8'h01, 8'h55, 8'ha7, 8'hff});
		host.sel(1'b0);
	endtask

	task automatic t_unsupported;
		logic [7:0] codes[6] =
			'{8'h05, 8'h09, 8'h0c, 8'hfc, 8'hfd, 8'hff};
		foreach (codes[i])
			txn('{codes[i], 8'ha7}, '{8'h04, 8'h00, 8'ha7, 8'hff});
	endtask

	task automatic t_errors;
		int p = pay_cnt;
		int d = drop_cnt;
		host.sel(1'b1);
		cmd('{8'hfe, 8'h86, 8'h11});
		rsp('{8'hff});
		host.sel(1'b0);
		chk({7'h0, o_host_attention_n}, 8'h00);
		chk(8'(pay_cnt - p), 8'h00);
		txn('{8'h0a, 8'ha7}, '{8'h01, 8'h00, 8'ha7, 8'hff});
		txn('{8'hfe, 8'h02, 8'h01, 8'h02, 8'h55},
			'{8'h03, 8'h00, 8'ha7, 8'hff});
		chk(8'(drop_cnt - d), 8'h01);
		host.sel(1'b1);
		cmd('{8'hfe, 8'h02, 8'h11});
		host.sel(1'b0);
		chk(8'(drop_cnt - d), 8'h02);
		txn('{8'h0c, 8'ha7}, '{8'h02, 8'h00, 8'ha7, 8'hff});
		txn('{8'h0a, 8'ha7}, '{8'h82, 8'ha7, 8'hff});
	endtask

	task automatic t_boot;
		int c;
		do_reset(1'b1, 1'b0);
		cause = 8'h05;
		do_reset(1'b0, 1'b1);
		txn('{8'h0a, 8'ha7}, '{8'h00, cause, 8'ha7, 8'hff});
		txn('{8'hfe, 8'h02, 8'h01, 8'h02, 8'ha7},
			'{8'h04, 8'h00, 8'ha7, 8'hff});
		c = commit_cnt;
		host.sel(1'b1);
		cmd('{8'hfd, 8'h02, 8'h01, 8'h02, 8'ha7});
		chk(8'(commit_cnt - c), 8'h01);
		chk({7'h0, pay_boot}, 8'h01);
		app_idx = 0;
		app_q = '{8'hfd, 8'h01, 8'h77};
		rsp('{8'hfd, 8'h01, 8'h77, 8'ha7, 8'hff});
		host.sel(1'b0);
	endtask

	initial
	begin
		i_sys_rst = 1'b1;
		i_wake_request_n = 1'b1;
		i_trace_data_pin = 1'b1;
		i_alive = 1'b1;
		// select already active while the device comes out of reset
		host.sel(1'b1);
		do_reset(1'b1, 1'b1);
		t_reset_notice;
		txn('{8'h0a, 8'ha7}, '{8'h82, 8'ha7, 8'hff});
		t_status;
		t_frame(2);
		t_frame(133);
		t_unsupported;
		t_errors;
		t_boot;
		final_report;
	end

	// whole run is a few hundred byte slots of six cycles each
	initial
	begin
		#400us;
		fails++;
		final_report;
	end
endmodule
